// ### rtc_trim_defs.svh
// Address map, field positions, reset values and timing counts for the
// trim, backup and timestamp block. Definitions only; included by name.
`ifndef RTC_TRIM_DEFS_SVH
`define RTC_TRIM_DEFS_SVH

// Control bytes (upper seven bits) that select the two address spaces.
`define CODE_CLOCK_SPACE    7'h6f
`define CODE_NV_SPACE       7'h57

// Clock register and SRAM address map.
`define ADDR_WEEKDAY_STATUS 8'h03
`define ADDR_CONTROL        8'h07
`define ADDR_OSC_TRIM       8'h08
`define ADDR_PD_MIN         8'h18
`define ADDR_PD_HOUR        8'h19
`define ADDR_PD_DATE        8'h1a
`define ADDR_PD_MONTH       8'h1b
`define ADDR_PU_MIN         8'h1c
`define ADDR_PU_HOUR        8'h1d
`define ADDR_PU_DATE        8'h1e
`define ADDR_PU_MONTH       8'h1f
`define ADDR_CLOCK_LAST     8'h1f
`define ADDR_SRAM_FIRST     8'h20
`define ADDR_SRAM_LAST      8'h5f

// Control register fields.
`define CTL_OUT             7
`define CTL_SQW_EN          6
`define CTL_ALM1_EN         5
`define CTL_ALM0_EN         4
`define CTL_EXT_OSC         3
`define CTL_COARSE          2
`define CTL_FSEL_HI         1
`define CTL_FSEL_LO         0

// Weekday and power status fields.
`define WKS_OSC_RUN         5
`define WKS_PWR_FAIL        4
`define WKS_BACKUP_EN       3
`define WKS_WEEKDAY_CODE_HI        2

// Trim register sign bit.
`define TRIM_SIGN           7

// Reset values.
`define RST_CONTROL         8'h00
`define RST_OSC_TRIM        8'h00
`define RST_WEEKDAY_STATUS  8'h00
`define RST_STAMP           8'h00

// Masks that force unimplemented timestamp bits to read as zero.
`define MASK_MIN            8'h7f
`define MASK_HOUR           8'h7f
`define MASK_DATE           8'h3f
`define MASK_MONTH          8'hff

// Timing: oscillator rate, trim rates and square wave half periods.
`define OSC_FREQ_HZ         32768
`define COARSE_RATE_HZ      128
`define FINE_PERIOD_S       60
`define COARSE_TICKS        (`OSC_FREQ_HZ / `COARSE_RATE_HZ)
`define FINE_TICKS          (`OSC_FREQ_HZ * `FINE_PERIOD_S)
`define HALF_1HZ            (`OSC_FREQ_HZ / 2)
`define HALF_4KHZ           4
`define HALF_8KHZ           2
`define HALF_64HZ           (`OSC_FREQ_HZ / 128)

`endif

// ### rtc_trim_pkg.sv
// Types shared by the trim, backup and timestamp block.
// Assumes nothing of its surroundings.
package rtc_trim_pkg;

	// Direction of a pending trim correction.
	typedef enum logic [1:0] {
		trim_idle,
		trim_remove,
		trim_add
	} trim_state_type;

	// Square wave frequency select codes.
	typedef enum logic [1:0] {
		sqw_1hz,
		sqw_4khz,
		sqw_8khz,
		sqw_32khz
	} sqw_select_type;

	// One byte of the register and SRAM space.
	typedef logic [7:0] byte_type;

endpackage

// ### rtc_trim_backup_timestamp.sv
// Trim, backup switchover, power-fail timestamp and clock/SRAM space.
// Assumes a decoded register port from the serial slave on the same clock,
// calendar fields from the counters, and async oscillator and supply pins.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_trim_defs.svh"

module rtc_trim_backup_timestamp #(
	parameter int FINE_TICKS = `FINE_TICKS
) (
	input  wire logic                   clock,
	input  wire logic                   reset,
	input  wire logic                   osc_clock,
	input  wire logic                   primary_above_threshold,
	input  wire logic                   oscillator_running_flag,
	input  wire logic                   alarm_output_level,
	input  wire logic                   nv_write_busy,
	input  wire rtc_trim_pkg::byte_type cal_minutes,
	input  wire rtc_trim_pkg::byte_type cal_hours,
	input  wire rtc_trim_pkg::byte_type cal_date,
	input  wire rtc_trim_pkg::byte_type cal_month,
	input  wire logic                   bus_req,
	input  wire logic                   bus_write,
	input  wire logic [6:0]             bus_control_code,
	input  wire rtc_trim_pkg::byte_type bus_addr,
	input  wire rtc_trim_pkg::byte_type bus_wdata,
	output var  logic                   bus_ack_r,
	output var  logic                   bus_nack_r,
	output var  rtc_trim_pkg::byte_type bus_rdata_r,
	output var  logic                   nv_select_r,
	output var  logic                   bus_enable_r,
	output var  logic                   backup_active_r,
	output var  logic                   trimmed_tick_r,
	output var  logic                   multi_function_output_r,
	output var  logic                   multi_function_oe_n_r
);
	import rtc_trim_pkg::*;

	// Synchronisers for the oscillator and the supply comparator.
	logic       osc_s1_r, osc_s2_r, osc_s3_r;      // Oscillator samples.
	logic       pwr_s1_r, pwr_s2_r;                // Comparator samples.
	logic       osc_s1_nxt, osc_s2_nxt, osc_s3_nxt;
	logic       pwr_s1_nxt, pwr_s2_nxt;
	logic       raw_tick;                          // Rising oscillator edge.

	// Register file.
	byte_type   control_r, control_nxt;            // Output and oscillator.
	byte_type   trim_r, trim_nxt;                  // Sign and trim value.
	logic       backup_enable_r, backup_enable_nxt;
	logic       power_failure_flag_r, power_failure_flag_nxt;
	logic       up_armed_r, up_armed_nxt;          // Waiting for power-up.
	logic [2:0] weekday_r, weekday_nxt;            // Weekday storage.
	byte_type   stamp_r [8];                       // Down then up stamps.
	byte_type   stamp_nxt [8];
	byte_type   sram [64];                         // General purpose SRAM.
	logic       backup_nxt, bus_enable_nxt;
	logic       ack_nxt, nack_nxt, nv_nxt;
	byte_type   rdata_nxt;

	// Trim sequencer.
	trim_state_type trim_state_r, trim_state_nxt;
	logic [20:0] interval_r, interval_nxt;         // Ticks in the interval.
	logic [7:0]  pending_r, pending_nxt;           // Ticks still to adjust.
	logic        tick_nxt;

	// Square wave and output pin.
	logic [14:0] sqw_count_r, sqw_count_nxt;       // Half period counter.
	logic        sqw_r, sqw_nxt;                   // Square wave level.
	logic        mfp_nxt;

	// Decoded bus request.
	logic       clock_space, nv_space, in_range, accept, do_write;
	logic       coarse;
	logic [6:0] trim_value;
	logic [14:0] half_period;

	assign clock_space = (bus_control_code == `CODE_CLOCK_SPACE);
	assign nv_space    = (bus_control_code == `CODE_NV_SPACE);
	assign in_range    = (bus_addr <= `ADDR_SRAM_LAST);
	// The nonvolatile busy input is deliberately not consulted here.
	assign accept      = bus_req && clock_space && in_range
		&& bus_enable_r;
	assign do_write    = accept && bus_write;
	assign coarse      = control_r[`CTL_COARSE];
	assign trim_value  = trim_r[6:0];
	assign raw_tick    = osc_s2_r && !osc_s3_r;

	// Next values of the synchronisers; the first stage feeds only the second.
	always_comb begin
		osc_s1_nxt = osc_clock;
		osc_s2_nxt = osc_s1_r;
		osc_s3_nxt = osc_s2_r;
		pwr_s1_nxt = primary_above_threshold;
		pwr_s2_nxt = pwr_s1_r;
	end

	// Registers the synchronisers.
	always_ff @(posedge clock) begin
		if (reset) begin
			osc_s1_r <= 1'b0;
			osc_s2_r <= 1'b0;
			osc_s3_r <= 1'b0;
			pwr_s1_r <= 1'b1;
			pwr_s2_r <= 1'b1;
		end else begin
			osc_s1_r <= osc_s1_nxt;
			osc_s2_r <= osc_s2_nxt;
			osc_s3_r <= osc_s3_nxt;
			pwr_s1_r <= pwr_s1_nxt;
			pwr_s2_r <= pwr_s2_nxt;
		end
	end

	// Trim sequencer: opens an interval, then removes or adds ticks.
	always_comb begin
		trim_state_nxt = trim_state_r;
		interval_nxt   = interval_r;
		pending_nxt    = pending_r;
		tick_nxt       = raw_tick;
		// The interval is counted on raw ticks and keeps running on backup.
		if (raw_tick) begin
			interval_nxt = interval_r + 21'd1;
		end
		if (raw_tick && ((coarse && interval_r >=
			21'(`COARSE_TICKS - 1)) || (!coarse && interval_r >=
			21'(FINE_TICKS - 1)))) begin
			interval_nxt = '0;
			if (trim_value == 7'h00) begin
				trim_state_nxt = trim_idle;
				pending_nxt    = '0;
			end else begin
				pending_nxt    = {trim_value, 1'b0};
				trim_state_nxt = trim_r[`TRIM_SIGN] ? trim_add
					: trim_remove;
			end
		end else begin
			unique case (trim_state_r)
				trim_idle: begin
					tick_nxt = raw_tick;
				end
				trim_remove: begin
					// A slow-down swallows real ticks until none remain.
					if (raw_tick) begin
						tick_nxt    = 1'b0;
						pending_nxt = pending_r - 8'd1;
						if (pending_r == 8'd1) begin
							trim_state_nxt = trim_idle;
						end
					end
				end
				trim_add: begin
					// Extra ticks slot into system cycles with no real tick.
					if (!raw_tick) begin
						tick_nxt    = 1'b1;
						pending_nxt = pending_r - 8'd1;
						if (pending_r == 8'd1) begin
							trim_state_nxt = trim_idle;
						end
					end
				end
			endcase
		end
	end

	// Registers the trim sequencer.
	always_ff @(posedge clock) begin
		if (reset) begin
			trim_state_r   <= trim_idle;
			interval_r     <= '0;
			pending_r      <= '0;
			trimmed_tick_r <= 1'b0;
		end else begin
			trim_state_r   <= trim_state_nxt;
			interval_r     <= interval_nxt;
			pending_r      <= pending_nxt;
			trimmed_tick_r <= tick_nxt;
		end
	end

	// Square wave from trimmed ticks, at full rate from the oscillator, and the output pin selection.
	always_comb begin
		unique case (sqw_select_type'(control_r[`CTL_FSEL_HI:`CTL_FSEL_LO]))
			sqw_1hz:   half_period = 15'(`HALF_1HZ);
			sqw_4khz:  half_period = 15'(`HALF_4KHZ);
			sqw_8khz:  half_period = 15'(`HALF_8KHZ);
			sqw_32khz: half_period = 15'd1;
		endcase
		if (coarse) begin
			half_period = 15'(`HALF_64HZ);
		end
		sqw_count_nxt = sqw_count_r;
		sqw_nxt       = sqw_r;
		if (!coarse && control_r[`CTL_FSEL_HI:`CTL_FSEL_LO] == 2'd3) begin
			// Full rate follows the oscillator itself, untrimmed.
			sqw_nxt = osc_s2_r;
		end else if (tick_nxt) begin
			if (sqw_count_r >= half_period - 15'd1) begin
				sqw_count_nxt = '0;
				sqw_nxt       = !sqw_r;
			end else begin
				sqw_count_nxt = sqw_count_r + 15'd1;
			end
		end
		// Backup keeps only the alarm output alive on the pin.
		if (!backup_active_r && control_r[`CTL_SQW_EN]) begin
			mfp_nxt = sqw_r;
		end else if (control_r[`CTL_ALM0_EN] || control_r[`CTL_ALM1_EN]) begin
			mfp_nxt = alarm_output_level;
		end else if (!backup_active_r) begin
			mfp_nxt = control_r[`CTL_OUT];
		end else begin
			mfp_nxt = 1'b1;
		end
	end

	// Registers the square wave and the open-drain pin.
	always_ff @(posedge clock) begin
		if (reset) begin
			sqw_count_r             <= '0;
			sqw_r                   <= 1'b0;
			multi_function_output_r <= 1'b0;
			multi_function_oe_n_r   <= 1'b1;
		end else begin
			sqw_count_r             <= sqw_count_nxt;
			sqw_r                   <= sqw_nxt;
			multi_function_output_r <= 1'b0;
			multi_function_oe_n_r   <= mfp_nxt;
		end
	end

	// Register file, switchover, timestamp capture and bus answers.
	always_comb begin
		control_nxt            = control_r;
		trim_nxt               = trim_r;
		backup_enable_nxt      = backup_enable_r;
		power_failure_flag_nxt = power_failure_flag_r;
		up_armed_nxt           = up_armed_r;
		weekday_nxt            = weekday_r;
		for (int i = 0; i < 8; i++) begin
			stamp_nxt[i] = stamp_r[i];
		end
		// Backup is entered only with the enable set and the supply low.
		backup_nxt     = backup_enable_r && !pwr_s2_r;
		bus_enable_nxt = !backup_nxt;
		ack_nxt        = accept;
		nack_nxt       = bus_req && clock_space && !accept;
		nv_nxt         = bus_req && nv_space && bus_enable_r;
		rdata_nxt      = 8'h00;

		// Register writes from software.
		if (do_write) begin
			unique case (bus_addr)
				`ADDR_CONTROL: control_nxt = bus_wdata;
				`ADDR_OSC_TRIM: trim_nxt = bus_wdata;
				`ADDR_WEEKDAY_STATUS: begin
					backup_enable_nxt = bus_wdata[`WKS_BACKUP_EN];
					weekday_nxt       = bus_wdata[`WKS_WEEKDAY_CODE_HI:0];
					// Software may only clear the flag, never set it.
					if (!bus_wdata[`WKS_PWR_FAIL]
						&& power_failure_flag_r) begin
						power_failure_flag_nxt = 1'b0;
						up_armed_nxt           = 1'b0;
						for (int i = 0; i < 8; i++) begin
							stamp_nxt[i] = `RST_STAMP;
						end
					end
				end
				`ADDR_PD_MIN, `ADDR_PU_MIN:
					stamp_nxt[bus_addr[2:0]] = bus_wdata & `MASK_MIN;
				`ADDR_PD_HOUR, `ADDR_PU_HOUR:
					stamp_nxt[bus_addr[2:0]] = bus_wdata & `MASK_HOUR;
				`ADDR_PD_DATE, `ADDR_PU_DATE:
					stamp_nxt[bus_addr[2:0]] = bus_wdata & `MASK_DATE;
				`ADDR_PD_MONTH, `ADDR_PU_MONTH:
					stamp_nxt[bus_addr[2:0]] = bus_wdata;
				default: begin
					// Calendar registers and SRAM are handled elsewhere.
				end
			endcase
		end

		// Power-down capture on the switchover edge, set wins over clear.
		if (backup_nxt && !backup_active_r && !power_failure_flag_r) begin
			stamp_nxt[0] = cal_minutes & `MASK_MIN;
			stamp_nxt[1] = cal_hours & `MASK_HOUR;
			stamp_nxt[2] = cal_date & `MASK_DATE;
			stamp_nxt[3] = cal_month;
			power_failure_flag_nxt = 1'b1;
			up_armed_nxt = 1'b1;
		end
		// Power-up capture once per outage, only for an armed outage.
		if (!backup_nxt && backup_active_r && up_armed_r) begin
			stamp_nxt[4] = cal_minutes & `MASK_MIN;
			stamp_nxt[5] = cal_hours & `MASK_HOUR;
			stamp_nxt[6] = cal_date & `MASK_DATE;
			stamp_nxt[7] = cal_month;
			up_armed_nxt = 1'b0;
		end

		// Read data for the clock space and SRAM.
		if (accept && !bus_write) begin
			if (bus_addr >= `ADDR_SRAM_FIRST) begin
				rdata_nxt = sram[6'(bus_addr - `ADDR_SRAM_FIRST)];
			end else if (bus_addr >= `ADDR_PD_MIN) begin
				rdata_nxt = stamp_r[bus_addr[2:0]];
			end else if (bus_addr == `ADDR_CONTROL) begin
				rdata_nxt = control_r;
			end else if (bus_addr == `ADDR_OSC_TRIM) begin
				rdata_nxt = trim_r;
			end else if (bus_addr == `ADDR_WEEKDAY_STATUS) begin
				rdata_nxt = {2'b00, oscillator_running_flag,
					power_failure_flag_r, backup_enable_r, weekday_r};
			end
		end
	end

	// Registers the register file and the bus answers.
	always_ff @(posedge clock) begin
		if (reset) begin
			control_r            <= `RST_CONTROL;
			trim_r               <= `RST_OSC_TRIM;
			backup_enable_r      <= 1'b0;
			power_failure_flag_r <= 1'b0;
			up_armed_r           <= 1'b0;
			weekday_r            <= 3'h0;
			for (int i = 0; i < 8; i++) begin
				stamp_r[i] <= `RST_STAMP;
			end
			backup_active_r      <= 1'b0;
			bus_enable_r         <= 1'b1;
			bus_ack_r            <= 1'b0;
			bus_nack_r           <= 1'b0;
			nv_select_r          <= 1'b0;
			bus_rdata_r          <= 8'h00;
		end else begin
			control_r            <= control_nxt;
			trim_r               <= trim_nxt;
			backup_enable_r      <= backup_enable_nxt;
			power_failure_flag_r <= power_failure_flag_nxt;
			up_armed_r           <= up_armed_nxt;
			weekday_r            <= weekday_nxt;
			for (int i = 0; i < 8; i++) begin
				stamp_r[i] <= stamp_nxt[i];
			end
			backup_active_r      <= backup_nxt;
			bus_enable_r         <= bus_enable_nxt;
			bus_ack_r            <= ack_nxt;
			bus_nack_r           <= nack_nxt;
			nv_select_r          <= nv_nxt;
			bus_rdata_r          <= rdata_nxt;
		end
	end

	// SRAM has no reset and never waits for the calendar update.
	always_ff @(posedge clock) begin
		if (do_write && bus_addr >= `ADDR_SRAM_FIRST) begin
			sram[6'(bus_addr - `ADDR_SRAM_FIRST)] <= bus_wdata;
		end
	end

endmodule
`default_nettype wire

// ### rtc_trim_backup_timestamp_sva.sv
// Port checks for the trim, backup and timestamp block.
// Assumes binding onto the block's top; one clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_trim_defs.svh"
module rtc_trim_backup_timestamp_sva #(
	parameter int FINE_TICKS = `FINE_TICKS
) (
	input wire logic                   clock,
	input wire logic                   reset,
	input wire logic                   primary_above_threshold,
	input wire logic                   bus_req,
	input wire logic [6:0]             bus_control_code,
	input wire rtc_trim_pkg::byte_type bus_addr,
	input wire logic                   bus_ack_r,
	input wire logic                   bus_nack_r,
	input wire rtc_trim_pkg::byte_type bus_rdata_r,
	input wire logic                   nv_select_r,
	input wire logic                   bus_enable_r,
	input wire logic                   backup_active_r
);
	import rtc_trim_pkg::*;

	// Every check samples on the rising clock and rests during reset.
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);

	// Request to the clock and SRAM space, and whether it is in the map.
	wire logic clk_req = bus_req && bus_control_code == `CODE_CLOCK_SPACE;
	wire logic nv_req  = bus_req && bus_control_code == `CODE_NV_SPACE;
	wire logic in_map  = bus_addr <= `ADDR_SRAM_LAST;

	AST_ACK_IN_MAP:
		assert property (clk_req && in_map && bus_enable_r |=> bus_ack_r)
		else $error("mapped request was not acknowledged");
	AST_NACK_PAST_END:
		assert property (clk_req && !in_map |=> bus_nack_r && !bus_ack_r)
		else $error("request past the map was not refused");
	AST_NV_PASSED:
		assert property (nv_req && bus_enable_r |=> nv_select_r && !bus_ack_r)
		else $error("nonvolatile request was not passed on");
	AST_BACKUP_REFUSE:
		assert property (bus_req && !bus_enable_r |=> !bus_ack_r && !nv_select_r)
		else $error("request accepted while on backup");
	AST_BACKUP_BUS_OFF:
		assert property (backup_active_r |-> !bus_enable_r)
		else $error("serial interface left on during backup");
	AST_ENTER_BACKUP:
		assert property ($rose(backup_active_r) |-> !$past(primary_above_threshold, 3))
		else $error("backup entered with primary above threshold");
	AST_LEAVE_BACKUP:
		assert property ($fell(backup_active_r) |-> $past(primary_above_threshold, 3))
		else $error("backup left with primary below threshold");
	AST_RDATA_ONLY_ACK:
		assert property (!bus_ack_r |-> bus_rdata_r == 8'h00)
		else $error("read data outside an acknowledge");
	AST_NO_STRAY_ACK:
		assert property (bus_ack_r |-> $past(bus_req) && !$past(nv_req))
		else $error("acknowledge without a clock space request");

	// Main scenarios reached by the bench.
	COV_BACKUP_IN: cover property ($rose(backup_active_r));
	COV_BACKUP_OUT: cover property ($fell(backup_active_r));
	COV_NACK: cover property (bus_nack_r);
	COV_NV: cover property (nv_select_r);
endmodule

bind rtc_trim_backup_timestamp rtc_trim_backup_timestamp_sva #(
	.FINE_TICKS(FINE_TICKS)
) sva_i (
	.clock(clock), .reset(reset), .bus_req(bus_req),
	.primary_above_threshold(primary_above_threshold),
	.bus_control_code(bus_control_code), .bus_addr(bus_addr),
	.bus_ack_r(bus_ack_r), .bus_nack_r(bus_nack_r),
	.bus_rdata_r(bus_rdata_r), .nv_select_r(nv_select_r),
	.bus_enable_r(bus_enable_r), .backup_active_r(backup_active_r)
);
`default_nettype wire

// ### rtc_osc_model.sv
// Far side model: a free-running, sped-up stand-in for the 32.768 kHz timekeeping oscillator.
// Assumes the bench wants an 80 ns period, unrelated in phase to clock.
`timescale 1ns/1ps
`default_nettype none
module rtc_osc_model #(
	parameter real HALF_NS = 40.0
) (
	output var logic osc_clock,
	output var logic oscillator_running_flag
);
	// The oscillator runs free from a 3 ns offset and reports running.
	initial begin
		osc_clock = 1'b0;
		oscillator_running_flag = 1'b1;
		#3;
		forever #(HALF_NS) osc_clock = ~osc_clock;
	end
endmodule
`default_nettype wire

// ### rtc_trim_backup_timestamp_test.sv
// Self-checking bench for the trim, backup and timestamp block.
// Assumes the oscillator model and the checker bound to the design.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_trim_defs.svh"
module rtc_trim_backup_timestamp_test;
	import rtc_trim_pkg::*;
	localparam int FINE = 512;
	logic       clock, reset, osc, running, primary, nv_busy, alarm;
	logic       req, wr, ack, nack, nv_sel, bus_en, backup, tick, mfo, oe_n;
	logic [6:0] code;
	byte_type   cmin, chour, cdate, cmonth, addr, wdata, rdata, got;
	int         errors, num_checks;
	// Calendar sets for captures; the last row is the cleared state.
	byte_type   cal_set [3][4] = '{'{8'h59, 8'h72, 8'h31, 8'he9},
		'{8'h07, 8'h23, 8'h01, 8'h32}, '{8'h00, 8'h00, 8'h00, 8'h00}};
	byte_type   masks [4] = '{8'h7f, 8'h7f, 8'h3f, 8'hff};

	rtc_trim_backup_timestamp #(.FINE_TICKS(FINE)) rtc_trim_backup_timestamp_i (
		.clock(clock), .reset(reset), .osc_clock(osc),
		.primary_above_threshold(primary), .oscillator_running_flag(running),
		.alarm_output_level(alarm), .nv_write_busy(nv_busy),
		.cal_minutes(cmin), .cal_hours(chour), .cal_date(cdate),
		.cal_month(cmonth), .bus_req(req), .bus_write(wr),
		.bus_control_code(code), .bus_addr(addr), .bus_wdata(wdata),
		.bus_ack_r(ack), .bus_nack_r(nack), .bus_rdata_r(rdata),
		.nv_select_r(nv_sel), .bus_enable_r(bus_en), .backup_active_r(backup),
		.trimmed_tick_r(tick), .multi_function_output_r(mfo),
		.multi_function_oe_n_r(oe_n));
	rtc_osc_model rtc_osc_model_i (.osc_clock(osc),
		.oscillator_running_flag(running));

	// The 125 MHz system clock.
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	// Counts a comparison and reports a mismatch.
	task automatic check(input string name, input logic [7:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic report_and_stop();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// One request held for one edge; the answer is read a cycle later.
	task automatic access(input logic w, input logic [6:0] c, input byte_type a, d);
		@(posedge clock);
		req <= 1'b1;
		wr <= w;
		code <= c;
		addr <= a;
		wdata <= d;
		@(posedge clock);
		req <= 1'b0;
		#1;
		got = rdata;
	endtask

	// Clock space write and read with their acknowledges checked.
	task automatic wr_reg(input byte_type a, d);
		access(1'b1, `CODE_CLOCK_SPACE, a, d);
		check("write ack", {7'h00, ack}, 8'h01);
	endtask
	task automatic rd_reg(input byte_type a, exp);
		access(1'b0, `CODE_CLOCK_SPACE, a, 8'h00);
		check("read ack", {7'h00, ack}, 8'h01);
		check("read data", got, exp);
	endtask

	// Presents one calendar set to the capture inputs.
	task automatic put_cal(input int s);
		@(posedge clock);
		cmin <= cal_set[s][0];
		chour <= cal_set[s][1];
		cdate <= cal_set[s][2];
		cmonth <= cal_set[s][3];
	endtask

	// Reads both stamp sets against two rows of the calendar table.
	task automatic stamps(input int d, u);
		for (int i = 0; i < 4; i++) begin
			rd_reg(`ADDR_PD_MIN + 8'(i), cal_set[d][i]);
			rd_reg(`ADDR_PU_MIN + 8'(i), cal_set[u][i]);
		end
	endtask

	// Moves the supply and waits, bounded, for the switchover.
	task automatic supply(input logic up, exp);
		int n;
		@(posedge clock);
		primary <= up;
		for (n = 0; n < 20 && backup !== exp; n++) begin
			@(posedge clock);
		end
		if (backup !== exp) begin
			check("switchover", {7'h00, backup}, {7'h00, exp});
			report_and_stop();
		end
		#1;
	endtask

	// Counts trimmed ticks and pin changes over a span of cycles.
	task automatic count(input int cycles, output int t, f);
		logic last;
		t = 0;
		f = 0;
		last = oe_n;
		repeat (cycles) begin
			@(posedge clock);
			#1;
			t += tick;
			f += (oe_n !== last);
			last = oe_n;
		end
	endtask

	// Measures 1024 raw ticks under one trim setting; the span holds k or
	// k+1 interval ends, each moving 2*v ticks. Added ticks are mirrored
	// around 1024 so one range serves both directions.
	task automatic trim_run(input logic crs, sgn, input int v, iv);
		int t, f, k, lo, hi;
		wr_reg(`ADDR_CONTROL, {2'b01, 3'b000, crs, 2'b00});
		wr_reg(`ADDR_OSC_TRIM, {sgn, 7'(v)});
		count(2600, t, f);
		count(10240, t, f);
		k = 1024 / iv;
		lo = 1024 - 2 * v * (k + 1) - 1;
		hi = 1024 - 2 * v * k + 1;
		if (sgn) begin
			t = 2048 - t;
		end
		check("tick count", {7'h00, t >= lo && t <= hi}, 8'h01);
		check("pin flips", {7'h00, crs ? (f >= 3 && f <= 5) : f <= 1}, 8'h01);
	endtask

	// Main sequence.
	initial begin
		int t, f;
		{reset, primary} = 2'b11;
		{alarm, nv_busy, req, wr, code, addr, wdata} = '0;
		{cmin, chour, cdate, cmonth, errors, num_checks} = '0;
		repeat (10) @(posedge clock);
		reset <= 1'b0;
		// Reset values, stamp placement and stamp bit masks.
		rd_reg(`ADDR_CONTROL, `RST_CONTROL);
		rd_reg(`ADDR_OSC_TRIM, `RST_OSC_TRIM);
		rd_reg(`ADDR_WEEKDAY_STATUS, 8'h20);
		stamps(2, 2);
		for (int i = 0; i < 8; i++) begin
			wr_reg(`ADDR_PD_MIN + 8'(i), 8'hff);
			rd_reg(`ADDR_PD_MIN + 8'(i), masks[i % 4]);
		end
		// SRAM ends stay open during a nonvolatile write; map edges.
		@(posedge clock);
		nv_busy <= 1'b1;
		wr_reg(`ADDR_SRAM_FIRST, 8'ha5);
		wr_reg(`ADDR_SRAM_LAST, 8'h5a);
		rd_reg(`ADDR_SRAM_FIRST, 8'ha5);
		rd_reg(`ADDR_SRAM_LAST, 8'h5a);
		@(posedge clock);
		nv_busy <= 1'b0;
		access(1'b1, `CODE_CLOCK_SPACE, 8'h60, 8'h11);
		check("nack past end", {7'h00, nack}, 8'h01);
		access(1'b0, `CODE_NV_SPACE, 8'h00, 8'h00);
		check("nv select", {7'h00, nv_sel}, 8'h01);
		check("nv no ack", {7'h00, ack}, 8'h00);
		// Trim rates, steps and the coarse square wave.
		trim_run(1'b1, 1'b0, 0, 256);
		trim_run(1'b1, 1'b0, 1, 256);
		trim_run(1'b1, 1'b1, 1, 256);
		trim_run(1'b0, 1'b0, 3, FINE);
		wr_reg(`ADDR_OSC_TRIM, 8'h00);
		// Square wave, first alarm and coarse mode all enabled.
		wr_reg(`ADDR_CONTROL, 8'h54);
		// Without backup enabled a supply drop changes nothing.
		@(posedge clock);
		primary <= 1'b0;
		repeat (20) @(posedge clock);
		check("no backup", {7'h00, backup}, 8'h00);
		check("bus kept", {7'h00, bus_en}, 8'h01);
		supply(1'b1, 1'b0);
		// Enabled backup: capture, suppressed outputs, running ticks.
		wr_reg(`ADDR_WEEKDAY_STATUS, 8'h08);
		put_cal(0);
		supply(1'b0, 1'b1);
		check("bus off", {7'h00, bus_en}, 8'h00);
		count(3000, t, f);
		check("backup ticks", {7'h00, t >= 299 && t <= 301}, 8'h01);
		check("no square wave", 8'(f), 8'h00);
		// The alarm level alone reaches the pin while on backup.
		check("alarm low on pin", {7'h00, oe_n}, 8'h00);
		check("pin drive value", {7'h00, mfo}, 8'h00);
		@(posedge clock);
		alarm <= 1'b1;
		@(posedge clock);
		#1;
		check("alarm high on pin", {7'h00, oe_n}, 8'h01);
		@(posedge clock);
		alarm <= 1'b0;
		access(1'b0, `CODE_CLOCK_SPACE, `ADDR_CONTROL, 8'h00);
		check("backup refused", {7'h00, ack}, 8'h00);
		put_cal(1);
		supply(1'b1, 1'b0);
		stamps(0, 1);
		rd_reg(`ADDR_WEEKDAY_STATUS, 8'h38);
		// A second failure with the flag set keeps the stamps.
		supply(1'b0, 1'b1);
		supply(1'b1, 1'b0);
		stamps(0, 1);
		// Clearing the flag clears all eight stamps.
		wr_reg(`ADDR_WEEKDAY_STATUS, 8'h08);
		rd_reg(`ADDR_WEEKDAY_STATUS, 8'h28);
		stamps(2, 2);
		report_and_stop();
	end
endmodule
`default_nettype wire
